// ===== pkg/hygcs_params.svh
`ifndef HYGCS_PARAMS_SVH
`define HYGCS_PARAMS_SVH

// Register indices; the byte address of each register is four times its index.
`define HYGCS_IDX_STATUS 8'h12
`define HYGCS_IDX_AOUT1 8'h1F
`define HYGCS_IDX_AOUT2 8'h20
`define HYGCS_IDX_UNITS 8'h22
`define HYGCS_IDX_IRQ_STAT 8'h40
`define HYGCS_IDX_IRQ_MASK 8'h41

// Default APB address width in bits.
`define HYGCS_ADDR_W 12

// Reset values of the software-visible registers.
`define HYGCS_RST_AOUT1 16'h0000
`define HYGCS_RST_AOUT2 16'h0000
`define HYGCS_RST_UNITS 16'h0000
`define HYGCS_RST_CTRL 7'h00
`define HYGCS_RST_IRQ 4'h0

// Measured-quantity codes for the analog output selectors.
`define HYGCS_QTY_DEWPOINT 8'h00
`define HYGCS_QTY_TEMP 8'h01
`define HYGCS_QTY_PPMV 8'h02
`define HYGCS_QTY_PPMW 8'h03
`define HYGCS_QTY_GKG 8'h04
`define HYGCS_QTY_GM3 8'h05
`define HYGCS_QTY_PRESSURE 8'h06
`define HYGCS_QTY_FLOW 8'h07
`define HYGCS_QTY_RH 8'h08
`define HYGCS_QTY_TDIFF 8'h09

// Analog output range codes.
`define HYGCS_RANGE_0_20MA 2'h0
`define HYGCS_RANGE_4_20MA 2'h1
`define HYGCS_RANGE_0_1V 2'h2

// Pressure unit codes.
`define HYGCS_PRESS_PSIG 2'h0
`define HYGCS_PRESS_BARA 2'h1
`define HYGCS_PRESS_KPA 2'h2
`define HYGCS_PRESS_MPAG 2'h3

// Decimal place codes.
`define HYGCS_DECIMAL_ONE 2'h0
`define HYGCS_DECIMAL_TWO 2'h1
`define HYGCS_DECIMAL_THREE 2'h2

// Mirror control state codes.
`define HYGCS_MIRROR_IN_CONTROL 2'h0
`define HYGCS_MIRROR_HEATING 2'h1
`define HYGCS_MIRROR_COOLING 2'h2

// Operating mode codes.
`define HYGCS_MODE_MEASURE 4'h0
`define HYGCS_MODE_CONTAMINATION 4'h1
`define HYGCS_MODE_HOLD 4'h2
`define HYGCS_MODE_MAX_COOL 4'h4
`define HYGCS_MODE_STANDBY 4'h8

// Interrupt status bit positions and width.
`define HYGCS_IRQ_W 4
`define HYGCS_IRQ_FAULT 0
`define HYGCS_IRQ_HUMIDITY 1
`define HYGCS_IRQ_MODE 2
`define HYGCS_IRQ_MIRROR 3

`endif

// ===== pkg/hygcs_pkg.sv
package hygcs_pkg;

  // First analog output configuration word.
  typedef struct packed {
    logic [7:0] quantity2;
    logic [7:0] quantity1;
  } hygcs_aout1_t;

  // Second analog output configuration word.
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] range3;
    logic [1:0] range2;
    logic [1:0] range1;
    logic [7:0] quantity3;
  } hygcs_aout2_t;

  // Display units and command word.
  typedef struct packed {
    logic [3:0] language;
    logic restoreDefaults;
    logic frostEnable;
    logic [1:0] decimalPlaces;
    logic spare7;
    logic coolerManual;
    logic [1:0] pressureUnit;
    logic wetBasis;
    logic rhOverIce;
    logic spare1;
    logic fahrenheit;
  } hygcs_units_t;

  // Writable bits of the instrument state word.
  typedef struct packed {
    logic opticsReset;
    logic displayHold;
    logic maxCool;
    logic contaminationCycle;
    logic logging;
    logic externalPrt;
    logic standby;
  } hygcs_ctrl_t;

  // State reported by the instrument into the state word.
  typedef struct packed {
    logic frostActive;
    logic faultAlarm;
    logic humidityAlarm;
    logic [1:0] mirrorControl;
    logic [3:0] operatingMode;
  } hygcs_sense_t;

  // One-cycle command pulses toward the instrument.
  typedef struct packed {
    logic opticsResetStart;
    logic maxCoolStart;
    logic contaminationToggle;
    logic restoreDefaults;
  } hygcs_cmd_t;

  // Complete state of the register bank.
  typedef struct packed {
    hygcs_aout1_t aout1;
    hygcs_aout2_t aout2;
    hygcs_units_t units;
    hygcs_ctrl_t ctrl;
    hygcs_sense_t sensePrev;
    hygcs_cmd_t cmd;
    logic [3:0] irqStatus;
    logic [3:0] irqMask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } hygcs_state_t;

endpackage

// ===== verif/hygcs_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "hygcs_params.svh"

module hygcs_regs_bench;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  hygcs_pkg::hygcs_sense_t senseIn;
  hygcs_pkg::hygcs_aout1_t aout1Cfg;
  hygcs_pkg::hygcs_aout2_t aout2Cfg;
  hygcs_pkg::hygcs_units_t unitsCfg;
  hygcs_pkg::hygcs_ctrl_t ctrlOut;
  hygcs_pkg::hygcs_cmd_t cmdPulse, lastPulse;
  int miscompares, checks;
  int cycles = 0;
  localparam logic [11:0] A_ST = 12'(`HYGCS_IDX_STATUS * 4);
  localparam logic [11:0] A_Q1 = 12'(`HYGCS_IDX_AOUT1 * 4);
  localparam logic [11:0] A_Q2 = 12'(`HYGCS_IDX_AOUT2 * 4);
  localparam logic [11:0] A_UN = 12'(`HYGCS_IDX_UNITS * 4);
  localparam logic [11:0] A_IS = 12'(`HYGCS_IDX_IRQ_STAT * 4);
  localparam logic [11:0] A_IM = 12'(`HYGCS_IDX_IRQ_MASK * 4);

  hygcs_regs DUT (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .senseIn(senseIn), .aout1Cfg(aout1Cfg), .aout2Cfg(aout2Cfg), .unitsCfg(unitsCfg), .ctrlOut(ctrlOut),
    .cmdPulse(cmdPulse), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // The system clock toggles every half period of 10 ns.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // A hung handshake is cut short here and counted as a mismatch.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value with its expectation and counts the outcome.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; data and error are taken at the rising edge that samples pready high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // The command pulses stand only in the cycle after the commit edge.
    @(posedge clk_sys);
    lastPulse = cmdPulse;
  endtask

  // Full-word register write.
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d}, 4'hF);
  endtask

  // Register read compared with a 16-bit expectation.
  task automatic rdq(input string what, input logic [11:0] a, input logic [15:0] exp);
    apb(1'b0, a, 32'h00000000, 4'hF);
    check(what, rd, {16'h0000, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // The configuration words, the state word and the interrupt come up cleared.
  task automatic t_reset;
    rdq("aout1", A_Q1, 16'h0000);
    rdq("aout2", A_Q2, 16'h0000);
    rdq("units", A_UN, 16'h0000);
    rdq("state", A_ST, 16'h0000);
    check("irq", 32'(irq), 32'h1 - 32'h1);
    $display("test reset done");
  endtask

  // Every quantity code lands in the first two selectors, and every range code in each range field.
  task automatic t_aout;
    for (int q = 0; q <= 9; q++) begin
      wr(A_Q1, 16'(((9 - q) << 8) | q));
      rdq("aout1", A_Q1, 16'(((9 - q) << 8) | q));
      check("quantity1", 32'(aout1Cfg.quantity1), 32'(q));
      check("quantity2", 32'(aout1Cfg.quantity2), 32'(9 - q));
    end
    // Only byte lane zero is written here, so the upper selector is kept.
    apb(1'b1, A_Q1, 32'h00007777, 4'h1);
    rdq("lane", A_Q1, 16'h0077);
    for (int r = 0; r < 3; r++) begin
      wr(A_Q2, 16'((r << 12) | (((r + 1) % 3) << 10) | (((r + 2) % 3) << 8) | (r + 5)));
      check("range3", 32'(aout2Cfg.range3), 32'(r));
      check("range2", 32'(aout2Cfg.range2), 32'((r + 1) % 3));
      check("range1", 32'(aout2Cfg.range1), 32'((r + 2) % 3));
      check("quantity3", 32'(aout2Cfg.quantity3), 32'(r + 5));
    end
    $display("test analog outputs done");
  endtask

  // Each units field but the language code follows what was written, and the restore bit pulses.
  task automatic t_units;
    for (int p = 0; p < 4; p++) begin
      wr(A_UN, 16'((p << 4) | ((p % 3) << 8) | ((p & 1) << 3) | ((p >> 1) << 2) | ((p & 1) << 6) | (p >> 1)));
      check("pressure", 32'(unitsCfg.pressureUnit), 32'(p));
      check("decimals", 32'(unitsCfg.decimalPlaces), 32'(p % 3));
      check("wet", 32'(unitsCfg.wetBasis), 32'(p & 1));
      check("ice", 32'(unitsCfg.rhOverIce), 32'(p >> 1));
      check("cooler", 32'(unitsCfg.coolerManual), 32'(p & 1));
      check("fahrenheit", 32'(unitsCfg.fahrenheit), 32'(p >> 1));
    end
    wr(A_UN, 16'h0C00);
    check("restore", 32'(lastPulse.restoreDefaults), 32'h1);
    check("frost", 32'(unitsCfg.frostEnable), 32'h1);
    rdq("units", A_UN, 16'h0C00);
    $display("test units done");
  endtask

  // Command bits act on write, and the reported fields ignore writes.
  task automatic t_state;
    logic [3:0] modes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    hygcs_pkg::hygcs_sense_t s;
    wr(A_ST, 16'h2000);
    check("maxCoolStart", 32'(lastPulse.maxCoolStart), 32'h1);
    check("maxCool", 32'(ctrlOut.maxCool), 32'h1);
    rdq("state", A_ST, 16'h2000);
    wr(A_ST, 16'h3800);
    check("toggle", 32'(lastPulse.contaminationToggle), 32'h1);
    check("cleanOn", 32'(ctrlOut.contaminationCycle), 32'h1);
    check("logOn", 32'(ctrlOut.logging), 32'h1);
    rdq("state", A_ST, 16'h3800);
    wr(A_ST, 16'h1000);
    check("cleanOff", 32'(ctrlOut.contaminationCycle), 32'h0);
    check("logOff", 32'(ctrlOut.logging), 32'h0);
    check("maxCoolOff", 32'(ctrlOut.maxCool), 32'h0);
    wr(A_ST, 16'h0000);
    check("noToggle", 32'(lastPulse.contaminationToggle), 32'h0);
    check("cleanKept", 32'(ctrlOut.contaminationCycle), 32'h0);
    wr(A_ST, 16'hC000);
    check("opticsStart", 32'(lastPulse.opticsResetStart), 32'h1);
    check("displayHold", 32'(ctrlOut.displayHold), 32'h1);
    for (int k = 0; k < 5; k++) begin
      s = hygcs_pkg::hygcs_sense_t'({k == 1, k == 2, k == 3, 2'(k % 3), modes[k]});
      senseIn <= s;
      repeat (4) @(posedge clk_sys);
      wr(A_ST, 16'h07FF);
      rdq("sense", A_ST, {5'h00, s.frostActive, s.faultAlarm, s.humidityAlarm, 2'h3, s.mirrorControl,
        s.operatingMode});
    end
    senseIn <= '0;
    repeat (4) @(posedge clk_sys);
    // An unmapped word answers with an error and zero data.
    apb(1'b0, 12'h004, 32'h00000000, 4'hF);
    check("slverr", 32'(err), 32'h1);
    check("zeroData", rd, 32'h00000000);
    $display("test state word done");
  endtask

  // Events latch, the mask gates the line, and writing one clears.
  task automatic t_irq;
    wr(A_IS, 16'h000F);
    wr(A_IM, 16'h0001);
    rdq("mask", A_IM, 16'h0001);
    senseIn.faultAlarm <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rdq("status", A_IS, 16'h0001);
    check("irqUp", 32'(irq), 32'h1);
    wr(A_IS, 16'h0001);
    check("irqDown", 32'(irq), 32'h0);
    senseIn.humidityAlarm <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rdq("sticky", A_IS, 16'h0002);
    check("masked", 32'(irq), 32'h0);
    wr(A_IM, 16'h0002);
    check("unmasked", 32'(irq), 32'h1);
    wr(A_IS, 16'h0002);
    check("cleared", 32'(irq), 32'h0);
    // A change of mode and of mirror state each latch their own bit.
    senseIn.operatingMode <= `HYGCS_MODE_HOLD;
    senseIn.mirrorControl <= `HYGCS_MIRROR_HEATING;
    repeat (5) @(posedge clk_sys);
    rdq("events", A_IS, 16'h000C);
    $display("test interrupt done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset for 20 cycles, then each test in turn.
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    senseIn = '0;
    miscompares = 0;
    checks = 0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_aout();
    t_units();
    t_state();
    t_irq();
    final_report();
  end
endmodule

`default_nettype wire

// ===== verilog/hygcs_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "hygcs_params.svh"

module hygcs_regs #(
  parameter int ADDR_W = `HYGCS_ADDR_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hygcs_pkg::hygcs_sense_t senseIn,
  output hygcs_pkg::hygcs_aout1_t aout1Cfg,
  output hygcs_pkg::hygcs_aout2_t aout2Cfg,
  output hygcs_pkg::hygcs_units_t unitsCfg,
  output hygcs_pkg::hygcs_ctrl_t ctrlOut,
  output hygcs_pkg::hygcs_cmd_t cmdPulse,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations and synchronisation.

  hygcs_pkg::hygcs_state_t stateReg;
  hygcs_pkg::hygcs_state_t stateNext;
  hygcs_pkg::hygcs_sense_t senseSync;
  logic [ADDR_W-3:0] wordIdx;
  logic aligned;
  logic hitStatus;
  logic hitAout1;
  logic hitAout2;
  logic hitUnits;
  logic hitIrqStat;
  logic hitIrqMask;
  logic mapped;
  logic setupPhase;
  logic accessWr;
  logic [15:0] statusView;
  logic [`HYGCS_IRQ_W-1:0] irqEvent;

  // Instrument state arrives from outside this clock domain.
  hygcs_sync #(
    .WIDTH($bits(hygcs_pkg::hygcs_sense_t))
  ) senseSyncInst (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(senseIn),
    .dout(senseSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and bus phases.

  // Word index and alignment of the current address.
  assign wordIdx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);

  // One select per mapped register.
  assign hitStatus = aligned && (wordIdx == (ADDR_W-2)'(`HYGCS_IDX_STATUS));
  assign hitAout1 = aligned && (wordIdx == (ADDR_W-2)'(`HYGCS_IDX_AOUT1));
  assign hitAout2 = aligned && (wordIdx == (ADDR_W-2)'(`HYGCS_IDX_AOUT2));
  assign hitUnits = aligned && (wordIdx == (ADDR_W-2)'(`HYGCS_IDX_UNITS));
  assign hitIrqStat = aligned && (wordIdx == (ADDR_W-2)'(`HYGCS_IDX_IRQ_STAT));
  assign hitIrqMask = aligned && (wordIdx == (ADDR_W-2)'(`HYGCS_IDX_IRQ_MASK));
  assign mapped = hitStatus || hitAout1 || hitAout2 || hitUnits || hitIrqStat || hitIrqMask;

  // The setup cycle prepares the answer; the access cycle commits writes.
  assign setupPhase = psel && !penable;
  assign accessWr = psel && penable && stateReg.pready && pwrite;

  // The state word as software reads it.
  assign statusView = {stateReg.ctrl.opticsReset, stateReg.ctrl.displayHold, stateReg.ctrl.maxCool,
                       stateReg.ctrl.contaminationCycle, stateReg.ctrl.logging, senseSync.frostActive,
                       senseSync.faultAlarm, senseSync.humidityAlarm, stateReg.ctrl.externalPrt,
                       stateReg.ctrl.standby, senseSync.mirrorControl, senseSync.operatingMode};

  // Events that set sticky interrupt bits.
  always_comb begin
    irqEvent = '0;
    irqEvent[`HYGCS_IRQ_FAULT] = senseSync.faultAlarm && !stateReg.sensePrev.faultAlarm;
    irqEvent[`HYGCS_IRQ_HUMIDITY] = senseSync.humidityAlarm && !stateReg.sensePrev.humidityAlarm;
    irqEvent[`HYGCS_IRQ_MODE] = senseSync.operatingMode != stateReg.sensePrev.operatingMode;
    irqEvent[`HYGCS_IRQ_MIRROR] = senseSync.mirrorControl != stateReg.sensePrev.mirrorControl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Merges the two low byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] wdata,
                                             input logic [3:0] strb);
    logic [15:0] merged;
    merged = old;
    if (strb[0]) begin
      merged[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = wdata[15:8];
    end
    return merged;
  endfunction

  // Bus answer, register writes, command pulses and interrupt bookkeeping.
  always_comb begin
    logic [15:0] stWord;
    logic [`HYGCS_IRQ_W-1:0] clearBits;
    stWord = statusView;
    clearBits = '0;
    stateNext = stateReg;
    stateNext.cmd = '0;
    stateNext.sensePrev = senseSync;
    stateNext.pready = setupPhase;
    stateNext.pslverr = setupPhase && !mapped;
    if (setupPhase) begin
      stateNext.prdata = '0;
      if (hitStatus) begin
        stateNext.prdata[15:0] = statusView;
      end else if (hitAout1) begin
        stateNext.prdata[15:0] = stateReg.aout1;
      end else if (hitAout2) begin
        stateNext.prdata[15:0] = stateReg.aout2;
      end else if (hitUnits) begin
        stateNext.prdata[15:0] = stateReg.units;
      end else if (hitIrqStat) begin
        stateNext.prdata[`HYGCS_IRQ_W-1:0] = stateReg.irqStatus;
      end else if (hitIrqMask) begin
        stateNext.prdata[`HYGCS_IRQ_W-1:0] = stateReg.irqMask;
      end
    end
    if (accessWr) begin
      if (hitAout1) begin
        stateNext.aout1 = mergeLanes(stateReg.aout1, pwdata, pstrb);
      end else if (hitAout2) begin
        stateNext.aout2 = mergeLanes(stateReg.aout2, pwdata, pstrb);
      end else if (hitUnits) begin
        stateNext.units = mergeLanes(stateReg.units, pwdata, pstrb);
        stateNext.cmd.restoreDefaults = pstrb[1] && pwdata[11];
      end else if (hitStatus) begin
        stWord = mergeLanes(statusView, pwdata, pstrb);
        stateNext.ctrl.opticsReset = stWord[15];
        stateNext.ctrl.displayHold = stWord[14];
        stateNext.ctrl.maxCool = stWord[13];
        stateNext.ctrl.logging = stWord[11];
        stateNext.ctrl.externalPrt = stWord[7];
        stateNext.ctrl.standby = stWord[6];
        stateNext.cmd.opticsResetStart = pstrb[1] && pwdata[15];
        stateNext.cmd.maxCoolStart = pstrb[1] && pwdata[13];
        if (pstrb[1] && pwdata[12]) begin
          stateNext.ctrl.contaminationCycle = !stateReg.ctrl.contaminationCycle;
          stateNext.cmd.contaminationToggle = 1'b1;
        end
      end else if (hitIrqStat) begin
        clearBits = pstrb[0] ? pwdata[`HYGCS_IRQ_W-1:0] : '0;
      end else if (hitIrqMask) begin
        if (pstrb[0]) begin
          stateNext.irqMask = pwdata[`HYGCS_IRQ_W-1:0];
        end
      end
    end
    // A new event wins over a clear in the same cycle.
    stateNext.irqStatus = (stateReg.irqStatus & ~clearBits) | irqEvent;
    stateNext.irq = |(stateNext.irqStatus & stateNext.irqMask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // All state clears to its defined value on reset.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stateReg <= '0;
      stateReg.aout1 <= `HYGCS_RST_AOUT1;
      stateReg.aout2 <= `HYGCS_RST_AOUT2;
      stateReg.units <= `HYGCS_RST_UNITS;
      stateReg.ctrl <= `HYGCS_RST_CTRL;
      stateReg.irqStatus <= `HYGCS_RST_IRQ;
      stateReg.irqMask <= `HYGCS_RST_IRQ;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Every output is a field of the state register.
  assign prdata = stateReg.prdata;
  assign pready = stateReg.pready;
  assign pslverr = stateReg.pslverr;
  assign aout1Cfg = stateReg.aout1;
  assign aout2Cfg = stateReg.aout2;
  assign unitsCfg = stateReg.units;
  assign ctrlOut = stateReg.ctrl;
  assign cmdPulse = stateReg.cmd;
  assign irq = stateReg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (reset);

  // A write access to the high lane of the state word.
  sequence wrStatusHi;
    accessWr && hitStatus && pstrb[1];
  endsequence

  // A read setup of the state word.
  sequence rdStatusSetup;
    setupPhase && !pwrite && hitStatus;
  endsequence

  // The bus answers exactly one cycle after setup, and only then.
  busAnswer_a: assert property (setupPhase |=> pready ##1 !pready)
    else $error("Access phase answer not one cycle after setup.");

  // Quantity selectors of outputs one and two follow a full write.
  aoutOneWrite_a: assert property (accessWr && hitAout1 && (pstrb[1:0] == 2'h3) |=>
    (aout1Cfg.quantity1 == $past(pwdata[7:0])) && (aout1Cfg.quantity2 == $past(pwdata[15:8])))
    else $error("Output one or two quantity not stored.");

  // Output three quantity follows a low lane write.
  aoutThreeQty_a: assert property (accessWr && hitAout2 && pstrb[0] |=>
    aout2Cfg.quantity3 == $past(pwdata[7:0]))
    else $error("Output three quantity not stored.");

  // Range fields land in their own bit pairs.
  aoutRanges_a: assert property (accessWr && hitAout2 && pstrb[1] |=>
    (aout2Cfg.range3 == $past(pwdata[13:12])) && (aout2Cfg.range2 == $past(pwdata[11:10])) &&
    (aout2Cfg.range1 == $past(pwdata[9:8])))
    else $error("Analog range fields misplaced.");

  // Maximum cooling starts with a single pulse and the bit reads back.
  maxCoolStart_a: assert property (wrStatusHi and pwdata[13] |=>
    (cmdPulse.maxCoolStart && ctrlOut.maxCool) ##1 !cmdPulse.maxCoolStart)
    else $error("Maximum cooling start missing.");

  // Writing one to the contamination bit flips the function.
  contamToggle_a: assert property (wrStatusHi and pwdata[12] |=>
    (ctrlOut.contaminationCycle != $past(ctrlOut.contaminationCycle)) && cmdPulse.contaminationToggle)
    else $error("Contamination cycle did not toggle.");

  // Writing zero to the contamination bit leaves it alone.
  contamHold_a: assert property (wrStatusHi and !pwdata[12] |=>
    $stable(ctrlOut.contaminationCycle))
    else $error("Contamination cycle changed without request.");

  // Logging follows the written bit.
  loggingCtrl_a: assert property (wrStatusHi |=> ctrlOut.logging == $past(pwdata[11]))
    else $error("Logging control not updated.");

  // Mirror control state and mode are returned from the instrument.
  statusSense_a: assert property (rdStatusSetup |=>
    (prdata[5:4] == $past(senseSync.mirrorControl)) && (prdata[3:0] == $past(senseSync.operatingMode)))
    else $error("Reported mirror state or mode wrong.");

  // Read-only state bits show the instrument, whatever was written.
  readOnlyBits_a: assert property (rdStatusSetup |=>
    (prdata[10:8] == {$past(senseSync.frostActive), $past(senseSync.faultAlarm),
                      $past(senseSync.humidityAlarm)}) && (prdata[31:16] == 16'h0000))
    else $error("Read-only state bits wrong.");

  // Pressure unit and decimal places follow a units write.
  unitsFormat_a: assert property (accessWr && hitUnits && (pstrb[1:0] == 2'h3) |=>
    (unitsCfg.pressureUnit == $past(pwdata[5:4])) && (unitsCfg.decimalPlaces == $past(pwdata[9:8])))
    else $error("Pressure unit or decimal places not stored.");

  // Calculation bases and cooler mode follow a units write.
  unitsCalc_a: assert property (accessWr && hitUnits && pstrb[0] |=>
    (unitsCfg.wetBasis == $past(pwdata[3])) && (unitsCfg.rhOverIce == $past(pwdata[2])) &&
    (unitsCfg.coolerManual == $past(pwdata[6])))
    else $error("Calculation or cooler setting not stored.");

  // Temperature unit, frost enable and restore request follow a units write.
  unitsCommand_a: assert property (accessWr && hitUnits && (pstrb[1:0] == 2'h3) |=>
    (unitsCfg.fahrenheit == $past(pwdata[0])) && (unitsCfg.frostEnable == $past(pwdata[10])) &&
    (cmdPulse.restoreDefaults == $past(pwdata[11])))
    else $error("Units command bits not handled.");

  // The interrupt line reflects unmasked sticky bits.
  irqLevel_a: assert property (irq == |(stateReg.irqStatus & stateReg.irqMask))
    else $error("Interrupt line disagrees with status and mask.");

  // A fault event survives a clear in the same cycle.
  irqSetWins_a: assert property (irqEvent[`HYGCS_IRQ_FAULT] |=> stateReg.irqStatus[`HYGCS_IRQ_FAULT])
    else $error("Fault event lost.");

  // An unmapped or misaligned address answers with an error and zero data.
  errorAnswer_a: assert property (setupPhase && !mapped |=> pslverr && (prdata == 32'h00000000))
    else $error("Unmapped access not refused.");

  // A mapped register answers without an error.
  mappedAnswer_a: assert property (setupPhase && mapped |=> !pslverr)
    else $error("Mapped access flagged as error.");

  // Configuration words change only through a committed write.
  cfgHold_a: assert property (!accessWr |=>
    $stable(aout1Cfg) && $stable(aout2Cfg) && $stable(unitsCfg))
    else $error("Configuration word changed without a write.");

  // Maximum cooling pulses only after a write of one to its bit.
  maxCoolOnly_a: assert property (!(accessWr && hitStatus && pstrb[1] && pwdata[13]) |=>
    !cmdPulse.maxCoolStart)
    else $error("Maximum cooling pulse without request.");

  // The contamination function holds between state word writes.
  contamKeep_a: assert property (!(accessWr && hitStatus) |=> $stable(ctrlOut.contaminationCycle))
    else $error("Contamination cycle changed on its own.");

  // Logging stays as it was between state word writes.
  loggingKeep_a: assert property (!(accessWr && hitStatus) |=> $stable(ctrlOut.logging))
    else $error("Logging changed without a write.");

  // A sticky bit stays set until software writes one to it.
  irqSticky_a: assert property (!(accessWr && hitIrqStat) |=>
    ((stateReg.irqStatus & $past(stateReg.irqStatus)) == $past(stateReg.irqStatus)))
    else $error("Sticky interrupt bit lost without a clear.");

  // Writing one clears a fault bit when no new fault arrives.
  irqClear_a: assert property (accessWr && hitIrqStat && pstrb[0] && pwdata[`HYGCS_IRQ_FAULT] &&
    !irqEvent[`HYGCS_IRQ_FAULT] |=> !stateReg.irqStatus[`HYGCS_IRQ_FAULT])
    else $error("Fault bit not cleared by write of one.");

  // A change of operating mode is latched as an event.
  modeEvent_a: assert property (senseSync.operatingMode != stateReg.sensePrev.operatingMode |=>
    stateReg.irqStatus[`HYGCS_IRQ_MODE])
    else $error("Mode change not latched.");

endmodule

`default_nettype wire

// ===== verilog/hygcs_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for a group of level inputs.
module hygcs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [1:0][WIDTH-1:0] syncReg;
  logic [1:0][WIDTH-1:0] syncNext;

  // The first stage feeds only the second stage.
  always_comb begin
    syncNext[0] = din;
    syncNext[1] = syncReg[0];
  end

  // Both stages clear on reset.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  assign dout = syncReg[1];

endmodule

`default_nettype wire
